// file: pirq_pkg.sv
// Constants shared by the peripheral interrupt enable and priority block.
// Assumes one 100 MHz clock and a simple strobe register port.
package pirq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SRC_W  = 8;

  // Register index map
  localparam logic [ADDR_W-1:0] OFS_ENABLE_B   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY_A = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY_B = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PRIORITY_C = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'h6;

  // Reset values
  localparam logic [DATA_W-1:0] RST_ENABLE_B   = 8'h00;
  localparam logic [DATA_W-1:0] RST_PRIORITY_A = 8'hff;
  localparam logic [DATA_W-1:0] RST_PRIORITY_B = 8'hcb;
  localparam logic [DATA_W-1:0] RST_PRIORITY_C = 8'hff;
  localparam logic              RST_LEVELS_ON  = 1'b0;

  // Writable bits; the rest hold their reset value and read as such
  localparam logic [DATA_W-1:0] WR_MASK_ENABLE_B   = 8'hcf;
  localparam logic [DATA_W-1:0] IMPL_MASK_PRIORITY_B = 8'hcb;

  // Field positions
  localparam int BIT_LEVELS_ON   = 7;
  localparam int BIT_RECEIVER2   = 5;
  localparam int BIT_TRANSMIT2   = 4;
  localparam int BIT_EV_HIGH     = 0;
  localparam int BIT_EV_LOW      = 1;
  localparam int EV_W            = 2;

  localparam logic [EV_W-1:0]   RST_IRQ_STATUS = 2'h0;
  localparam logic [EV_W-1:0]   RST_IRQ_MASK   = 2'h0;

endpackage : pirq_pkg

// file: pirq_route.sv
// Per-source gating and level routing for one group of sources.
// Assumes flags, enables and priorities all come from the same clock.
`timescale 1ns/1ns
module pirq_route #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] flag,
  input  wire logic [N-1:0] enable,
  input  wire logic [N-1:0] prio,
  input  wire logic         levelsOn,
  output logic      [N-1:0] highOut,
  output logic      [N-1:0] lowOut
);

  logic [N-1:0] gated;

  assign gated = flag & enable;

  // Single level: every source lands on the high output
  assign highOut = levelsOn ? (gated & prio) : gated;
  assign lowOut  = levelsOn ? (gated & ~prio) : '0;

endmodule : pirq_route

// file: pirq_irq_status.sv
// Sticky event status with write-one-to-clear.
// Assumes events and clears are on the same clock.
`timescale 1ns/1ns
module pirq_irq_status
  import pirq_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] event_in,
  input  wire logic         clrWr,
  input  wire logic [W-1:0] clrData,
  output logic      [W-1:0] status
);

  // Set wins over clear so a same-cycle event is not lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      status <= (status & ~(clrWr ? clrData : '0)) | event_in;
    end
  end

  a_set_wins: assert property (@(posedge clk) disable iff (!resetn)
    event_in[0] |=> status[0])
    else $error("event lost against clear");

endmodule : pirq_irq_status

// file: pirq_top.sv
// Peripheral interrupt enable and priority block, register side and routing.
// Assumes peripheral flags are synchronous to clk; strobes last one cycle.
`timescale 1ns/1ns
module pirq_top
  import pirq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic [SRC_W-1:0]  grpAFlag,
  input  wire logic [SRC_W-1:0]  grpAEnable,
  input  wire logic [SRC_W-1:0]  grpBFlag,
  input  wire logic [SRC_W-1:0]  grpBEnable,
  input  wire logic [SRC_W-1:0]  grpCFlag,
  output logic                   highReq,
  output logic                   lowReq,
  output logic                   irq
);

  logic [DATA_W-1:0] periphIntEnableB;
  logic [DATA_W-1:0] periphIntPriorityA;
  logic [DATA_W-1:0] periphIntPriorityB;
  logic [DATA_W-1:0] periphIntPriorityC;
  logic              priorityLevelsOn;
  logic [EV_W-1:0]   irqMask;
  logic [EV_W-1:0]   irqStatus;
  logic [EV_W-1:0]   events;
  logic [SRC_W-1:0]  hiA;
  logic [SRC_W-1:0]  loA;
  logic [SRC_W-1:0]  hiB;
  logic [SRC_W-1:0]  loB;
  logic [SRC_W-1:0]  hiC;
  logic [SRC_W-1:0]  loC;
  logic              next_highReq;
  logic              next_lowReq;
  logic [DATA_W-1:0] next_rdData;
  logic              wrEnB;
  logic              wrPrA;
  logic              wrPrB;
  logic              wrPrC;
  logic              wrRst;
  logic              wrSta;
  logic              wrMsk;
  logic              maskedAny;
  logic              anyFlag;

  assign wrEnB = wrStb && (addr == OFS_ENABLE_B);
  assign wrPrA = wrStb && (addr == OFS_PRIORITY_A);
  assign wrPrB = wrStb && (addr == OFS_PRIORITY_B);
  assign wrPrC = wrStb && (addr == OFS_PRIORITY_C);
  assign wrRst = wrStb && (addr == OFS_RESET_CTRL);
  assign wrSta = wrStb && (addr == OFS_IRQ_STATUS);
  assign wrMsk = wrStb && (addr == OFS_IRQ_MASK);

  // Enable B: receiver 2 and transmitter 2 enables stay at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periphIntEnableB <= RST_ENABLE_B;
    end else if (wrEnB) begin
      periphIntEnableB <= wrData & WR_MASK_ENABLE_B;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periphIntPriorityA <= RST_PRIORITY_A;
    end else if (wrPrA) begin
      periphIntPriorityA <= wrData;
    end
  end

  // Unimplemented priority B bits are forced to zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periphIntPriorityB <= RST_PRIORITY_B;
    end else if (wrPrB) begin
      periphIntPriorityB <= wrData & IMPL_MASK_PRIORITY_B;
    end
  end

  // Third priority register serves the enable B sources
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periphIntPriorityC <= RST_PRIORITY_C;
    end else if (wrPrC) begin
      periphIntPriorityC <= wrData;
    end
  end

  // Only bit 7 of reset control lives here; cause flags read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      priorityLevelsOn <= RST_LEVELS_ON;
    end else if (wrRst) begin
      priorityLevelsOn <= wrData[BIT_LEVELS_ON];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqMask <= RST_IRQ_MASK;
    end else if (wrMsk) begin
      irqMask <= wrData[EV_W-1:0];
    end
  end

  pirq_route #(.N(SRC_W)) u_route_a (
    .flag     (grpAFlag),
    .enable   (grpAEnable),
    .prio     (periphIntPriorityA),
    .levelsOn (priorityLevelsOn),
    .highOut  (hiA),
    .lowOut   (loA)
  );

  pirq_route #(.N(SRC_W)) u_route_b (
    .flag     (grpBFlag & IMPL_MASK_PRIORITY_B),
    .enable   (grpBEnable),
    .prio     (periphIntPriorityB),
    .levelsOn (priorityLevelsOn),
    .highOut  (hiB),
    .lowOut   (loB)
  );

  pirq_route #(.N(SRC_W)) u_route_c (
    .flag     (grpCFlag),
    .enable   (periphIntEnableB),
    .prio     (periphIntPriorityC),
    .levelsOn (priorityLevelsOn),
    .highOut  (hiC),
    .lowOut   (loC)
  );

  assign next_highReq = |{hiA, hiB, hiC};
  assign next_lowReq  = |{loA, loB, loC};

  // Registered so the core sees glitch-free levels, one cycle late
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      highReq <= 1'b0;
      lowReq  <= 1'b0;
    end else begin
      highReq <= next_highReq;
      lowReq  <= next_lowReq;
    end
  end

  // A request level rising is the event software hears about
  assign events[BIT_EV_HIGH] = next_highReq && !highReq;
  assign events[BIT_EV_LOW]  = next_lowReq && !lowReq;

  pirq_irq_status #(.W(EV_W)) u_status (
    .clk      (clk),
    .resetn   (resetn),
    .event_in (events),
    .clrWr    (wrSta),
    .clrData  (wrData[EV_W-1:0]),
    .status   (irqStatus)
  );

  assign maskedAny = |(irqStatus & irqMask);
  // Only the assertions read this; it names the raw flag activity
  assign anyFlag   = |{grpAFlag, grpBFlag, grpCFlag};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= maskedAny;
    end
  end

  always_comb begin
    next_rdData = '0;
    if (rdStb) begin
      case (addr)
        OFS_ENABLE_B:   next_rdData = periphIntEnableB;
        OFS_PRIORITY_A: next_rdData = periphIntPriorityA;
        OFS_PRIORITY_B: next_rdData = periphIntPriorityB;
        OFS_PRIORITY_C: next_rdData = periphIntPriorityC;
        OFS_RESET_CTRL: next_rdData = {priorityLevelsOn, 7'h00};
        OFS_IRQ_STATUS: next_rdData = {6'h00, irqStatus};
        OFS_IRQ_MASK:   next_rdData = {6'h00, irqMask};
        default:        next_rdData = '0;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_enable_blocks: assert property (
    ((grpAFlag & grpAEnable) == '0)
      && ((grpBFlag & grpBEnable & IMPL_MASK_PRIORITY_B) == '0)
      && ((grpCFlag & periphIntEnableB) == '0) |=> !highReq && !lowReq)
    else $error("disabled source reached the core");

  a_enb_readonly: assert property (
    !periphIntEnableB[BIT_RECEIVER2] && !periphIntEnableB[BIT_TRANSMIT2])
    else $error("read-only enable bit was set");

  a_prio_high: assert property (
    priorityLevelsOn && grpAEnable[0] && grpAFlag[0]
      && periphIntPriorityA[0] |=> highReq)
    else $error("high priority source not on high output");

  a_prio_low: assert property (
    priorityLevelsOn && grpAEnable[7] && grpAFlag[7]
      && !periphIntPriorityA[7] |=> lowReq)
    else $error("low priority source not on low output");

  a_single_level: assert property (
    !priorityLevelsOn |=> !lowReq)
    else $error("low output used without priority levels");

  a_prio_a_write: assert property (
    wrPrA |=> (periphIntPriorityA == $past(wrData)))
    else $error("priority A write not stored");

  a_prio_b_unimpl: assert property (
    (periphIntPriorityB & ~IMPL_MASK_PRIORITY_B) == '0)
    else $error("unimplemented priority B bit set");

  a_levels_read: assert property (
    rdStb && (addr == OFS_RESET_CTRL) && !wrStb
      |=> rdData == {$past(priorityLevelsOn), 7'h00})
    else $error("reset control read wrong");

  a_req_needs_flag: assert property (
    highReq || lowReq |-> $past(anyFlag))
    else $error("request without any flag");

  a_read_one_cycle: assert property (
    !rdStb |=> rdData == '0)
    else $error("read data outside answer cycle");

  a_irq_level: assert property (
    ##1 irq == $past(maskedAny))
    else $error("irq does not follow masked status");

endmodule : pirq_top

// file: pirq_core_model.sv
// Core side model: remembers which request levels it has seen.
// Assumes requests are synchronous to clk; clrSeen forgets them.
`timescale 1ns/1ns
module pirq_core_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic highReq,
  input  wire logic lowReq,
  input  wire logic clrSeen,
  output logic      seenHigh,
  output logic      seenLow
);
  // Sticky, so a one-cycle glitch on a request is not missed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seenHigh <= 1'b0;
      seenLow  <= 1'b0;
    end else begin
      seenHigh <= !clrSeen && (seenHigh || highReq);
      seenLow  <= !clrSeen && (seenLow || lowReq);
    end
  end
endmodule : pirq_core_model

// file: tb_pirq_top.sv
// Self-checking bench for the interrupt enable and priority block.
// Assumes one 100 MHz clock; the bench plays register master and sources.
`timescale 1ns/1ns
module tb_pirq_top;
  import pirq_pkg::*;
  typedef struct packed {
    logic       lv;
    logic [7:0] pr;
    logic [7:0] en;
    logic [7:0] fl;
    logic       hi;
    logic       lo;
  } pirq_row_t;
  logic              clk, resetn, wrStb, rdStb, clrSeen;
  logic              highReq, lowReq, irq, seenHigh, seenLow;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData;
  logic [SRC_W-1:0]  grpAFlag, grpAEnable, grpBFlag, grpBEnable, grpCFlag;
  int                mismatches, cmp_count, cyc;
  pirq_row_t rows [8] = '{
    '{1'b0, 8'hff, 8'h01, 8'h01, 1'b1, 1'b0},
    '{1'b0, 8'h00, 8'h01, 8'h01, 1'b1, 1'b0},
    '{1'b1, 8'h01, 8'h01, 8'h01, 1'b1, 1'b0},
    '{1'b1, 8'h00, 8'h80, 8'h80, 1'b0, 1'b1},
    '{1'b1, 8'h0f, 8'h00, 8'hff, 1'b0, 1'b0},
    '{1'b1, 8'h0f, 8'hff, 8'h00, 1'b0, 1'b0},
    '{1'b1, 8'h0f, 8'h30, 8'hf0, 1'b0, 1'b1},
    '{1'b1, 8'h0f, 8'h11, 8'h11, 1'b1, 1'b1}};

  pirq_top dut (.clk, .resetn, .addr, .wrData, .wrStb, .rdStb, .rdData,
    .grpAFlag, .grpAEnable, .grpBFlag, .grpBEnable, .grpCFlag,
    .highReq, .lowReq, .irq);
  pirq_core_model core (.clk, .resetn, .highReq, .lowReq, .clrSeen,
    .seenHigh, .seenLow);

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask : chk1
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk8(rdData, e);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    {resetn, wrStb, rdStb, clrSeen, addr, wrData} = '0;
    {grpAFlag, grpAEnable, grpBFlag, grpBEnable, grpCFlag} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    #1 chk1(highReq | lowReq | irq, 1'b0);
    rd(OFS_ENABLE_B, 8'h00);
    rd(OFS_PRIORITY_A, 8'hff);
    rd(OFS_PRIORITY_B, 8'hcb);
    rd(OFS_RESET_CTRL, 8'h00);
    wr(OFS_ENABLE_B, 8'hff);
    rd(OFS_ENABLE_B, 8'hcf);
    wr(OFS_PRIORITY_B, 8'h00);
    rd(OFS_PRIORITY_B, 8'h00);
    wr(OFS_PRIORITY_B, 8'hff);
    rd(OFS_PRIORITY_B, 8'hcb);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(OFS_RESET_CTRL, 8'hff);
    rd(OFS_RESET_CTRL, 8'h80);
    foreach (rows[i]) begin
      wr(OFS_RESET_CTRL, {rows[i].lv, 7'h0});
      wr(OFS_PRIORITY_A, rows[i].pr);
      @(posedge clk);
      grpAEnable <= rows[i].en;
      grpAFlag <= rows[i].fl;
      settle();
      chk1(highReq, rows[i].hi);
      chk1(lowReq, rows[i].lo);
    end
    // Unimplemented priority bits must not route anything
    @(posedge clk);
    grpAFlag <= 8'h00;
    grpBEnable <= 8'hff;
    grpBFlag <= 8'h34;
    settle();
    chk1(highReq | lowReq, 1'b0);
    @(posedge clk);
    grpBFlag <= 8'h08;
    settle();
    chk1(highReq, 1'b1);
    wr(OFS_PRIORITY_B, 8'h00);
    settle();
    chk1(lowReq, 1'b1);
    chk1(highReq, 1'b0);
    @(posedge clk);
    grpBFlag <= 8'h00;
    clrSeen <= 1'b1;
    wr(OFS_ENABLE_B, 8'h00);
    @(posedge clk);
    clrSeen <= 1'b0;
    grpCFlag <= 8'hff;
    settle();
    chk1(seenHigh | seenLow, 1'b0);
    wr(OFS_ENABLE_B, 8'hff);
    settle();
    chk1(highReq, 1'b1);
    chk1(seenHigh, 1'b1);
    @(posedge clk);
    grpCFlag <= 8'h30;
    settle();
    chk1(highReq | lowReq, 1'b0);
    @(posedge clk);
    grpCFlag <= 8'h00;
    rd(OFS_IRQ_STATUS, 8'h03);
    chk1(irq, 1'b0);
    wr(OFS_IRQ_STATUS, 8'h03);
    rd(OFS_IRQ_STATUS, 8'h00);
    wr(OFS_IRQ_MASK, 8'h01);
    rd(OFS_IRQ_MASK, 8'h01);
    @(posedge clk);
    grpAEnable <= 8'h01;
    grpAFlag <= 8'h01;
    repeat (2) settle();
    chk1(irq, 1'b1);
    @(posedge clk);
    grpAFlag <= 8'h00;
    wr(OFS_IRQ_STATUS, 8'h01);
    settle();
    chk1(irq, 1'b0);
    // Second reset in mid-run must restore the power-on values
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_PRIORITY_A, 8'hff);
    rd(OFS_ENABLE_B, 8'h00);
    rd(OFS_RESET_CTRL, 8'h00);
    give_verdict();
  end
endmodule : tb_pirq_top
